// ==== fps_consts.svh ====
// Timing counts, thresholds and state codes for the flight phase sequencer.
// Assumes a 20 MHz system clock; included by name from the design files.
`ifndef FPS_CONSTS_SVH
`define FPS_CONSTS_SVH
`define FPS_CLK_HZ 20000000
`define FPS_ACTIVE_MS 500
`define FPS_ACTIVE_CYC ((`FPS_CLK_HZ / 1000) * `FPS_ACTIVE_MS)
`define FPS_APOGEE_MS 1000
`define FPS_APOGEE_CYC ((`FPS_CLK_HZ / 1000) * `FPS_APOGEE_MS)
`define FPS_CHECK_S 5
`define FPS_CHECK_CYC (`FPS_CLK_HZ * `FPS_CHECK_S)
`define FPS_TAIL_S 10
`define FPS_TAIL_CYC (`FPS_CLK_HZ * `FPS_TAIL_S)
`define FPS_BEEP_S 1
`define FPS_BEEP_CYC (`FPS_CLK_HZ * `FPS_BEEP_S)
`define FPS_BEEP_ON_CYC 16'h4e20
`define FPS_LOW_APOGEE_M 16'sh00c8
`define FPS_MAIN_ALT_DEF_M 16'sh00c8
`define FPS_ST_BURNOUT 4'h3
`define FPS_ST_LANDED 4'h9
`define FPS_ST_BEEP 4'hb
`endif

// ==== fps_pkg.sv ====
// Types shared by the flight phase sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package fps_pkg;
  typedef enum logic [3:0] {
    FPS_S0, FPS_S1, FPS_S2, FPS_S3, FPS_S4, FPS_S5,
    FPS_S6, FPS_S7, FPS_S8, FPS_S9, FPS_S10, FPS_S11
  } fps_state_t;
  typedef enum logic [2:0] {
    FPS_EV_STAGE2_FIRE, FPS_EV_STAGE2_BURN, FPS_EV_APOGEE, FPS_EV_MIN_VEL,
    FPS_EV_DROGUE, FPS_EV_MAIN, FPS_EV_LANDING
  } fps_event_t;
endpackage

// ==== fps_sequencer.sv ====
// Flight phase sequencer for states 3 to 11 of a rocket flight recorder.
// Assumes filtered sensor values arrive one per sample_i strobe, and that
// earlier phases hand over with burnout_i once they reach state 3.
`timescale 1ns/10ps
`include "fps_consts.svh"
module fps_sequencer #(
  parameter int DATA_W = 16,
  parameter int TIME_W = 32,
  parameter int CNT_W = 32,
  parameter int ACTIVE_CYC = `FPS_ACTIVE_CYC,
  parameter int APOGEE_CYC = `FPS_APOGEE_CYC,
  parameter int CHECK_CYC = `FPS_CHECK_CYC,
  parameter int TAIL_CYC = `FPS_TAIL_CYC,
  parameter int BEEP_CYC = `FPS_BEEP_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic burnout_i,
  input wire logic sample_i,
  input wire logic signed [DATA_W-1:0] accel_i,
  input wire logic [DATA_W-1:0] pressure_i,
  input wire logic signed [DATA_W-1:0] altitude_i,
  input wire logic signed [DATA_W-1:0] velocity_i,
  input wire logic signed [DATA_W-1:0] descent_rate_i,
  input wire logic [DATA_W-1:0] main_alt_i,
  input wire logic [CNT_W-1:0] stage2_delay_i,
  input wire logic landed_i,
  input wire logic [TIME_W-1:0] time_i,
  input wire logic summary_done_i,
  output fps_pkg::fps_state_t state_o,
  output logic stage2_fuse_o,
  output logic drogue_fuse_o,
  output logic main_fuse_o,
  output logic stamp_valid_o,
  output fps_pkg::fps_event_t stamp_event_o,
  output logic [TIME_W-1:0] stamp_time_o,
  output logic [DATA_W-1:0] min_pressure_o,
  output logic logging_o,
  output logic summary_write_o,
  output logic buzzer_o
);
  import fps_pkg::*;

  fps_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [DATA_W-1:0] pmin_r, pmin_nxt;
  logic [CNT_W-1:0] rise_r, rise_nxt;
  logic apogee_r, apogee_nxt;
  logic signed [DATA_W-1:0] vmin_r, vmin_nxt;
  logic signed [DATA_W-1:0] rate_r, rate_nxt;
  logic check_en_r, check_en_nxt;
  logic s2f_r, s2f_nxt, drf_r, drf_nxt, mnf_r, mnf_nxt;
  logic stv_r, stv_nxt;
  fps_event_t sev_r, sev_nxt;
  logic [TIME_W-1:0] stt_r, stt_nxt;
  logic log_r, log_nxt, sum_r, sum_nxt, buz_r, buz_nxt;
  logic timer_load;
  logic [CNT_W-1:0] timer_count;
  logic timer_done;
  logic active;
  logic apo_now;
  logic drogue_go;
  logic [CNT_W-1:0] beep_on;

  // Stamp an event; a second stamp in one cycle overrides the first.
  function automatic logic [TIME_W+3:0] stamp(input fps_event_t ev,
                                              input logic [TIME_W-1:0] t);
    stamp = {1'b1, ev, t};
  endfunction

  // The timer is shared: each state that waits on it (3, 7 and 9) reloads it on entry.
  fps_timer #(.WIDTH(CNT_W)) u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(timer_load),
    .count_i(timer_count),
    .done_o(timer_done)
  );

  // Acceleration is already filtered upstream, so its sign is trusted.
  assign active = (accel_i > 0);
  assign apo_now = apogee_r | (rise_r >= CNT_W'(APOGEE_CYC));
  assign beep_on = CNT_W'(`FPS_BEEP_ON_CYC);
  // Drogue trails the apogee flag by at least one cycle so both stamps survive.
  assign drogue_go = apogee_r & ((altitude_i < `FPS_LOW_APOGEE_M)
                     | (sample_i & (velocity_i > vmin_r)));

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pmin_nxt = pmin_r;
    rise_nxt = rise_r;
    apogee_nxt = apogee_r;
    vmin_nxt = vmin_r;
    rate_nxt = rate_r;
    check_en_nxt = check_en_r;
    s2f_nxt = 1'b0;
    drf_nxt = 1'b0;
    mnf_nxt = 1'b0;
    {stv_nxt, sev_nxt, stt_nxt} = {1'b0, sev_r, stt_r};
    log_nxt = log_r;
    sum_nxt = 1'b0;
    buz_nxt = buz_r;
    timer_load = 1'b0;
    timer_count = '0;
    if (sample_i && (state_r == FPS_S4 || state_r == FPS_S6)) begin
      if (pressure_i < pmin_r) begin
        pmin_nxt = pressure_i;
        rise_nxt = '0;
      end else if (pressure_i == pmin_r) begin
        rise_nxt = '0;
      end
      if (velocity_i < vmin_r) begin
        vmin_nxt = velocity_i;
      end
    end
    if ((state_r == FPS_S4 || state_r == FPS_S6) && rise_r < CNT_W'(APOGEE_CYC)
        && !(sample_i && pressure_i <= pmin_r)) begin
      rise_nxt = rise_r + 1'b1;
    end
    case (state_r)
      FPS_S0, FPS_S1, FPS_S2: begin
        if (burnout_i) begin
          state_nxt = FPS_S3;
          log_nxt = 1'b1;
          timer_load = 1'b1;
          timer_count = stage2_delay_i;
        end
      end
      FPS_S3: begin
        if (timer_done) begin
          s2f_nxt = 1'b1;
          {stv_nxt, sev_nxt, stt_nxt} = stamp(FPS_EV_STAGE2_FIRE, time_i);
          state_nxt = FPS_S4;
          cnt_nxt = '0;
          pmin_nxt = '1;
          rise_nxt = '0;
          apogee_nxt = 1'b0;
          vmin_nxt = {1'b0, {(DATA_W-1){1'b1}}};
        end
      end
      FPS_S4: begin
        if (active) begin
          cnt_nxt = cnt_r + 1'b1;
          rise_nxt = '0;
          if (cnt_r + 1'b1 >= CNT_W'(ACTIVE_CYC)) begin
            state_nxt = FPS_S5;
          end
        end else begin
          cnt_nxt = '0;
          if (apo_now && !apogee_r) begin
            apogee_nxt = 1'b1;
            {stv_nxt, sev_nxt, stt_nxt} = stamp(FPS_EV_APOGEE, time_i);
          end
          if (drogue_go) begin
            drf_nxt = 1'b1;
            {stv_nxt, sev_nxt, stt_nxt} = stamp(FPS_EV_MIN_VEL, time_i);
            state_nxt = FPS_S7;
            timer_load = 1'b1;
            timer_count = CNT_W'(CHECK_CYC);
            check_en_nxt = 1'b1;
            rate_nxt = descent_rate_i;
          end
        end
      end
      FPS_S5: begin
        if (!active) begin
          {stv_nxt, sev_nxt, stt_nxt} = stamp(FPS_EV_STAGE2_BURN, time_i);
          state_nxt = FPS_S6;
          rise_nxt = '0;
        end
      end
      FPS_S6: begin
        if (apo_now && !apogee_r) begin
          apogee_nxt = 1'b1;
          {stv_nxt, sev_nxt, stt_nxt} = stamp(FPS_EV_APOGEE, time_i);
        end
        if (drogue_go) begin
          drf_nxt = 1'b1;
          {stv_nxt, sev_nxt, stt_nxt} = stamp(FPS_EV_MIN_VEL, time_i);
          state_nxt = FPS_S7;
          timer_load = 1'b1;
          timer_count = CNT_W'(CHECK_CYC);
          check_en_nxt = 1'b1;
          rate_nxt = descent_rate_i;
        end
      end
      FPS_S7: begin
        if (timer_done) begin
          check_en_nxt = 1'b0;
        end
        if (sample_i) begin
          rate_nxt = descent_rate_i;
        end
        if ((altitude_i < $signed(main_alt_i))
            || (check_en_r && !timer_done && sample_i
                && descent_rate_i > rate_r)) begin
          mnf_nxt = 1'b1;
          {stv_nxt, sev_nxt, stt_nxt} = stamp(FPS_EV_MAIN, time_i);
          state_nxt = FPS_S8;
          check_en_nxt = 1'b0;
        end
      end
      FPS_S8: begin
        if (landed_i) begin
          {stv_nxt, sev_nxt, stt_nxt} = stamp(FPS_EV_LANDING, time_i);
          state_nxt = FPS_S9;
          buz_nxt = 1'b1;
          timer_load = 1'b1;
          timer_count = CNT_W'(TAIL_CYC);
        end
      end
      FPS_S9: begin
        if (timer_done) begin
          state_nxt = FPS_S10;
          log_nxt = 1'b0;
          buz_nxt = 1'b0;
        end
      end
      FPS_S10: begin
        sum_nxt = 1'b1;
        if (summary_done_i) begin
          sum_nxt = 1'b0;
          state_nxt = FPS_S11;
          cnt_nxt = '0;
        end
      end
      FPS_S11: begin
        // Beep is a short burst each second so the battery lasts.
        cnt_nxt = (cnt_r + 1'b1 >= CNT_W'(BEEP_CYC)) ? '0 : cnt_r + 1'b1;
        buz_nxt = (cnt_nxt < beep_on);
      end
      default: begin
        state_nxt = FPS_S0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= FPS_S0;
      cnt_r <= '0;
      pmin_r <= '1;
      rise_r <= '0;
      apogee_r <= 1'b0;
      vmin_r <= '0;
      rate_r <= '0;
      check_en_r <= 1'b0;
      s2f_r <= 1'b0;
      drf_r <= 1'b0;
      mnf_r <= 1'b0;
      stv_r <= 1'b0;
      sev_r <= FPS_EV_STAGE2_FIRE;
      stt_r <= '0;
      log_r <= 1'b0;
      sum_r <= 1'b0;
      buz_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pmin_r <= pmin_nxt;
      rise_r <= rise_nxt;
      apogee_r <= apogee_nxt;
      vmin_r <= vmin_nxt;
      rate_r <= rate_nxt;
      check_en_r <= check_en_nxt;
      s2f_r <= s2f_nxt;
      drf_r <= drf_nxt;
      mnf_r <= mnf_nxt;
      stv_r <= stv_nxt;
      sev_r <= sev_nxt;
      stt_r <= stt_nxt;
      log_r <= log_nxt;
      sum_r <= sum_nxt;
      buz_r <= buz_nxt;
    end
  end

  assign state_o = state_r;
  assign stage2_fuse_o = s2f_r;
  assign drogue_fuse_o = drf_r;
  assign main_fuse_o = mnf_r;
  assign stamp_valid_o = stv_r;
  assign stamp_event_o = sev_r;
  assign stamp_time_o = stt_r;
  assign min_pressure_o = pmin_r;
  assign logging_o = log_r;
  assign summary_write_o = sum_r;
  assign buzzer_o = buz_r;

  no_drogue_s5_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state_r == FPS_S5 |=> !drf_r) else $error("drogue fired in state 5");
  s3_to_s4_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state_r == FPS_S3 && state_nxt == FPS_S4 |=> s2f_r && state_r == FPS_S4)
    else $error("stage two fuse missing on leaving state 3");
  s4_active_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state_r == FPS_S4 && active |=> !drf_r)
    else $error("drogue fired while stage two active");
  s4_to_s5_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state_r == FPS_S4 && !active |=> state_r != FPS_S5)
    else $error("left state 4 without stage two active");
  drogue_s7_a: assert property (@(posedge clk_i) disable iff (reset_i)
    drf_r |-> state_r == FPS_S7) else $error("drogue without state 7");
  main_s8_a: assert property (@(posedge clk_i) disable iff (reset_i)
    mnf_r |-> state_r == FPS_S8 && stv_r && sev_r == FPS_EV_MAIN)
    else $error("main fuse without state 8 stamp");
  landing_buzz_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state_r == FPS_S8 && landed_i |=> state_r == FPS_S9 && buz_r && log_r)
    else $error("landing did not start buzzer");
  s10_nolog_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state_r == FPS_S10 |-> !log_r) else $error("logging in state 10");
  s11_stay_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state_r == FPS_S11 |=> state_r == FPS_S11)
    else $error("left state 11");
  low_apogee_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state_r == FPS_S6 && apogee_r && altitude_i < `FPS_LOW_APOGEE_M
    |=> drf_r) else $error("low apogee drogue late");
endmodule

// ==== fps_sequencer_tb_top.sv ====
// Self-checking bench for the flight phase sequencer: two complete flights.
// Assumes fps_pkg, fps_timer, fps_sequencer and fps_consts.svh are present.
`timescale 1ns/10ps
`include "fps_consts.svh"
module fps_sequencer_tb_top;
  import fps_pkg::*;
  localparam int ACT = 10;
  localparam int APO = 20;
  localparam int CHKC = 50;
  localparam int TAIL = 50;
  localparam int BEEP = 40000;
  logic clk_i = 0, reset_i = 1, burnout_i = 0, sample_i = 0;
  logic signed [15:0] accel_i = 0, altitude_i = 0, velocity_i = 0;
  logic signed [15:0] descent_rate_i = 0;
  logic [15:0] pressure_i = 0, main_alt_i = 16'h00c8;
  logic [31:0] stage2_delay_i = 0, time_i = 0;
  logic landed_i = 0, summary_done_i = 0;
  fps_state_t state_o;
  fps_event_t stamp_event_o;
  logic stage2_fuse_o, drogue_fuse_o, main_fuse_o, stamp_valid_o;
  logic [31:0] stamp_time_o;
  logic [15:0] min_pressure_o;
  logic logging_o, summary_write_o, buzzer_o;
  int mismatches = 0, checks_done = 0, cnt, cyc = 0, prev = 0, e, d, c0;
  int p, v, dr, pmin, pj = 0, hi, vdir = -1, ddir = 0;
  bit asc = 1, s = 0;
  int ev_at [8];
  int exp_q [$];

  fps_sequencer #(.ACTIVE_CYC(ACT), .APOGEE_CYC(APO), .CHECK_CYC(CHKC),
    .TAIL_CYC(TAIL), .BEEP_CYC(BEEP)) dut (.clk_i, .reset_i, .burnout_i,
    .sample_i, .accel_i, .pressure_i, .altitude_i, .velocity_i,
    .descent_rate_i, .main_alt_i, .stage2_delay_i, .landed_i, .time_i,
    .summary_done_i, .state_o, .stage2_fuse_o, .drogue_fuse_o, .main_fuse_o,
    .stamp_valid_o, .stamp_event_o, .stamp_time_o, .min_pressure_o,
    .logging_o, .summary_write_o, .buzzer_o);

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // Sensor values move only on strobe cycles, so each step is one sample.
  always @(negedge clk_i) begin
    if (reset_i) begin
      p = 3000;
      v = 500;
      dr = 0;
      pmin = 65535;
    end else if (!s) begin
      p = asc ? p - 1 : p + pj;
      v = v + vdir;
      dr = dr + ddir;
      if (p < pmin) pmin = p;
    end
    sample_i <= !s && !reset_i;
    s = ~s;
    pressure_i <= p[15:0];
    velocity_i <= v[15:0];
    descent_rate_i <= dr[15:0];
  end

  function automatic bit legal(int a, int b);
    return (a < 3 && b == 3) || (a >= 3 && a < 11 && b == a + 1) ||
      (a == 4 && b == 7);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude;
    $display("mismatches %0d, checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic nb(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic wait_st(input int st, input int lim);
    cnt = 0;
    while (state_o !== st[3:0] && cnt < lim) begin
      @(posedge clk_i);
      #2;
      cnt++;
    end
    if (state_o !== st[3:0]) begin
      chk(state_o, st);
      conclude();
    end
  endtask

  always @(posedge clk_i) begin
    #1;
    cyc++;
    if (reset_i) begin
      prev = 0;
    end else begin
      if (state_o !== prev) chk(legal(prev, state_o), 1);
      if (stage2_fuse_o === 1'b1) chk(prev == 3 && state_o == FPS_S4, 1);
      if (drogue_fuse_o === 1'b1)
        chk((prev == 4 || prev == 6) && state_o == FPS_S7, 1);
      if (main_fuse_o === 1'b1) chk(prev == 7 && state_o == FPS_S8, 1);
      if (stamp_valid_o === 1'b1) begin
        e = exp_q.size() > 0 ? exp_q.pop_front() : 7;
        chk(stamp_event_o, e);
        chk(stamp_time_o, time_i);
        ev_at[stamp_event_o] = cyc;
      end
      prev = state_o;
    end
  end

  task automatic rst;
    nb(1);
    reset_i <= 1;
    asc <= 1;
    vdir <= -1;
    ddir <= 0;
    landed_i <= 0;
    summary_done_i <= 0;
    nb(3);
    chk(state_o, 0);
    chk(min_pressure_o, 16'hffff);
    chk({stamp_valid_o, stage2_fuse_o, drogue_fuse_o, main_fuse_o}, 0);
    chk(buzzer_o, 0);
    reset_i <= 0;
  endtask

  task automatic fly(input bit two, input int alt, input int malt);
    for (int i = 0; i < 8; i++) ev_at[i] = 0;
    d = $urandom_range(20, 5);
    stage2_delay_i <= d;
    main_alt_i <= malt[15:0];
    altitude_i <= alt[15:0];
    accel_i <= two ? 16'sd0 : -16'sd3;
    time_i <= $urandom;
    exp_q.push_back(FPS_EV_STAGE2_FIRE);
    burnout_i <= 1;
    wait_st(3, 4);
    wait_st(4, d + 10);
    chk(cnt, d + 2);
    nb(1);
    burnout_i <= 0;
    if (two) begin
      accel_i <= 16'sd50;
      nb(5);
      accel_i <= 16'sd0;
      nb(1);
      accel_i <= 16'sd50;
      chk(state_o, 4);
      wait_st(5, ACT + 5);
      chk(cnt >= ACT - 1 && cnt <= ACT + 2, 1);
      nb(1);
      time_i <= $urandom;
      exp_q.push_back(FPS_EV_STAGE2_BURN);
      nb(20);
      chk(state_o, 5);
      accel_i <= -16'sd3;
      wait_st(6, 5);
      nb(6);
    end
    time_i <= $urandom;
    exp_q.push_back(FPS_EV_APOGEE);
    exp_q.push_back(FPS_EV_MIN_VEL);
    asc <= 0;
    pj <= 5;
    nb(2);
    pj <= 0;
    c0 = cyc;
    if (!two) begin
      nb(10);
      pj <= -5;
      nb(2);
      pj <= 5;
      nb(2);
      pj <= 0;
      c0 = cyc;
      nb(APO + 30);
      chk(state_o, 4);
      chk(ev_at[2] >= c0 + APO - 3 && ev_at[2] > 0, 1);
      vdir <= 1;
      wait_st(7, 10);
    end else begin
      wait_st(7, APO + 10);
      chk(cyc >= c0 + APO - 3, 1);
      chk(ev_at[3] - ev_at[2] <= 2, 1);
    end
    chk(min_pressure_o, pmin);
    nb(1);
    time_i <= $urandom;
    exp_q.push_back(FPS_EV_MAIN);
    if (two) begin
      nb(CHKC + 10);
      ddir <= 1;
      nb(20);
      chk(state_o, 7);
      altitude_i <= 16'sd90;
      wait_st(8, 5);
    end else begin
      ddir <= 1;
      wait_st(8, 10);
    end
    nb(1);
    time_i <= $urandom;
    exp_q.push_back(FPS_EV_LANDING);
    landed_i <= 1;
    wait_st(9, 5);
    chk({buzzer_o, logging_o}, 2'b11);
    wait_st(10, TAIL + 5);
    chk(cnt >= TAIL - 2 && cnt <= TAIL + 2, 1);
    chk(logging_o, 0);
    nb(5);
    chk({state_o, logging_o, summary_write_o}, {4'ha, 2'b01});
    summary_done_i <= 1;
    wait_st(11, 5);
    chk(summary_write_o, 0);
    chk(exp_q.size(), 0);
  endtask

  initial begin
    void'($urandom(4994));
    rst();
    fly(0, 300, 200);
    rst();
    fly(1, 150, 100);
    hi = 0;
    repeat (BEEP) begin
      @(posedge clk_i);
      #1;
      hi += buzzer_o;
    end
    chk(hi, `FPS_BEEP_ON_CYC);
    chk(state_o, 11);
    conclude();
  end
endmodule

// ==== fps_timer.sv ====
// Down counter that reports when a loaded interval has elapsed.
// Assumes a synchronous active-high reset and a single clock.
`timescale 1ns/10ps
module fps_timer #(
  parameter int WIDTH = 32
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] count_i,
  output logic done_o
);
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    if (load_i) begin
      cnt_nxt = count_i;
      done_nxt = 1'b0;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end else begin
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r & ~load_i;
endmodule
